// *** gpc_bank.sv ***
// gpio pin configuration bank for pins 3.1 to 3.7 and 4.0, ahb-lite slave
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`include "gpc_params.svh"

// Behaviour
// - bit 0 sets direction, 1 input, 0 output.
// - bit 1 set inverts the pin value both ways.
// - bit 2 set gives the pin to its one alternate function.
// - bit 7 set selects open-drain, clear selects push-pull.
// - standby-power reset loads 0x01 into every register.
// - pin 3.1 register, bit 2 routes fan tachometer input.
// - pin 3.2 register, bit 2 routes smbus data.
// - pin 3.3 register, bit 2 fan speed; 0x00 on main/hard reset.
// - pin 3.4 register, bit 2 routes irq12.
// - pin 3.5 register, bit 2 routes irq14.
// - pin 3.6 register, bit 2 routes keyboard reset output.
// - pin 3.7 register, bit 2 routes address 20 gate.
// - pin 4.0 register, bit 2 routes drive density select 0.
module gpc_bank import gpc_pkg::*; (
  // clock and standby-power reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // main-power and hard resets, asynchronous levels
  input wire logic main_power_reset_in,
  input wire logic hard_reset_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // plain gpio data, index 0 is pin 3.1, index 7 is pin 4.0
  input wire logic [7:0] gpio_data_in,
  output logic [7:0] gpio_level_out,
  // alternate functions
  input wire gpc_alt_tx_s alt_tx_in,
  output gpc_alt_rx_s alt_rx_out,
  // pads
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe_n_out,
  // configuration view
  output logic [7:0][7:0] cfg_out
);

  // ----------------------------------------------------------------
  // pin index positions
  // ----------------------------------------------------------------
  localparam int P31 = 0;
  localparam int P32 = 1;
  localparam int P33 = 2;
  localparam int P34 = 3;
  localparam int P35 = 4;
  localparam int P36 = 5;
  localparam int P37 = 6;
  localparam int P40 = 7;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  gpc_bank_state_s st;
  gpc_bank_state_s next_st;
  gpc_ahb_req_s req;
  gpc_ahb_rsp_s rsp;
  logic [1:0] rst_async;
  logic [1:0] rst_sync;
  logic main_rst;
  logic [7:0] pad_sync;
  logic [7:0] alt_drive;
  logic [7:0] alt_level;
  logic [9:0] word_idx;
  logic xfer;
  logic cfg_hit;
  logic [2:0] cfg_sel;
  logic [7:0] alt_active;

  // ----------------------------------------------------------------
  // bus request bundle
  // ----------------------------------------------------------------
  always_comb begin
    req.hsel = hsel_in;
    req.haddr = haddr_in;
    req.htrans = htrans_in;
    req.hwrite = hwrite_in;
    req.hsize = hsize_in;
    req.hready = hready_in;
    req.hwdata = hwdata_in;
  end

  // ----------------------------------------------------------------
  // reset synchronisers
  // ----------------------------------------------------------------
  assign rst_async = {hard_reset_in, main_power_reset_in};

  gpc_sync2 #(
    .W(2)
  ) u_rst_sync (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .async_in(rst_async),
    .sync_out(rst_sync)
  );

  assign main_rst = rst_sync[0] | rst_sync[1];

  // ----------------------------------------------------------------
  // pad input synchronisers
  // ----------------------------------------------------------------
  gpc_sync2 #(
    .W(8)
  ) u_pad_sync (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .async_in(pad_in),
    .sync_out(pad_sync)
  );

  // ----------------------------------------------------------------
  // alternate function drive sources
  // ----------------------------------------------------------------
  always_comb begin
    alt_drive = 8'hff;
    // tachometer and irq14 are inputs; idle high if turned to output
    alt_drive[P31] = 1'b1;
    alt_drive[P32] = alt_tx_in.smbus_data_line;
    alt_drive[P33] = alt_tx_in.fan_speed_out;
    alt_drive[P34] = alt_tx_in.irq12;
    alt_drive[P35] = 1'b1;
    alt_drive[P36] = alt_tx_in.keyboard_reset_out;
    alt_drive[P37] = alt_tx_in.addr20_gate_out;
    alt_drive[P40] = alt_tx_in.drive_density_sel0;
  end

  // ----------------------------------------------------------------
  // alternate function receive paths
  // ----------------------------------------------------------------
  always_comb begin
    alt_rx_out.fan_tachometer_in = alt_level[P31];
    alt_rx_out.smbus_data_line = alt_level[P32];
    alt_rx_out.irq12 = alt_level[P34];
    alt_rx_out.irq14 = alt_level[P35];
  end

  // ----------------------------------------------------------------
  // pin cells
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_pin
    gpc_pin_cell u_cell (
      .cfg_in(st.cfg[i]),
      .gpio_data_in(gpio_data_in[i]),
      .alt_data_in(alt_drive[i]),
      .gpio_level_out(gpio_level_out[i]),
      .alt_level_out(alt_level[i]),
      .pad_sync_in(pad_sync[i]),
      .pad_out(pad_out[i]),
      .pad_oe_n_out(pad_oe_n_out[i])
    );
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  always_comb begin
    word_idx = req.haddr[11:2];
    xfer = req.hsel & req.hready & req.htrans[1];
    cfg_hit = (req.haddr[31:12] == 20'h00000)
              && (word_idx >= `GPC_IDX_PIN_3_1)
              && (word_idx <= `GPC_IDX_PIN_4_0);
    cfg_sel = 3'(word_idx - `GPC_IDX_PIN_3_1);
  end

  // ----------------------------------------------------------------
  // status views
  // ----------------------------------------------------------------
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      alt_active[k] = st.cfg[k][`GPC_BIT_FUNC];
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // data phase of an earlier write
    if (st.wr_pend) begin
      next_st.cfg[st.wr_sel] = req.hwdata[7:0] & `GPC_CFG_WMASK;
    end
    // main-power or hard reset clears pin 3.3 only
    if (main_rst) begin
      next_st.cfg[P33] = `GPC_CFG_MAIN_RST;
    end
    // address phase
    next_st.wr_pend = xfer & req.hwrite & cfg_hit;
    next_st.wr_sel = cfg_sel;
    if (xfer && !req.hwrite) begin
      // read sees any write finishing in this same cycle
      if (cfg_hit) begin
        next_st.rdata = {24'h000000, next_st.cfg[cfg_sel]};
      end else if (word_idx == `GPC_IDX_PIN_LEVEL
                   && req.haddr[31:12] == 20'h00000) begin
        next_st.rdata = {16'h0000, alt_level, gpio_level_out};
      end else if (word_idx == `GPC_IDX_ALT_ACTIVE
                   && req.haddr[31:12] == 20'h00000) begin
        next_st.rdata = {24'h000000, alt_active};
      end else begin
        next_st.rdata = 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      for (int k = 0; k < 8; k++) begin
        st.cfg[k] <= `GPC_CFG_RST;
      end
      st.wr_pend <= 1'b0;
      st.wr_sel <= 3'h0;
      st.rdata <= 32'h00000000;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // bus response
  // ----------------------------------------------------------------
  always_comb begin
    rsp.hrdata = st.rdata;
    rsp.hreadyout = 1'b1;
    rsp.hresp = 1'b0;
  end

  assign hrdata_out = rsp.hrdata;
  assign hreadyout_out = rsp.hreadyout;
  assign hresp_out = rsp.hresp;
  assign cfg_out = st.cfg;

endmodule

// *** gpc_bank_props.sv ***
// assertions on the ports of the gpio pin configuration bank
`timescale 1ns/1ps
module gpc_bank_chk import gpc_pkg::*; (
  // clock and resets
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic main_power_reset_in,
  input wire logic hard_reset_in,
  // bus
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  // pins
  input wire logic [7:0] gpio_data_in,
  input wire gpc_alt_tx_s alt_tx_in,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe_n_out,
  input wire logic [7:0][7:0] cfg_out
);
  // ----
  // field views
  // ----
  logic [7:0] dir_b, pol_b, fn_b, od_b, rsv_b, alt_v, wd8;
  logic take;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      dir_b[i] = cfg_out[i][0];
      pol_b[i] = cfg_out[i][1];
      fn_b[i] = cfg_out[i][2];
      od_b[i] = cfg_out[i][7];
      rsv_b[i] = |cfg_out[i][6:3];
    end
  end
  // input-only alternates drive 1
  assign alt_v = {alt_tx_in.drive_density_sel0, alt_tx_in.addr20_gate_out,
    alt_tx_in.keyboard_reset_out, 1'b1, alt_tx_in.irq12, alt_tx_in.fan_speed_out,
    alt_tx_in.smbus_data_line, 1'b1};
  assign wd8 = hwdata_in[7:0];
  assign take = hsel_in && hready_in && htrans_in[1] && haddr_in[31:12] == 20'h0
    && haddr_in[11:2] >= 10'h034 && haddr_in[11:2] <= 10'h03b;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // ----
  // properties
  // ----
  property p_okay;
    hreadyout_out && !hresp_out;
  endproperty
  a_okay: assert property (p_okay) else $error("bus answer not okay");
  property p_dir;
    (pad_oe_n_out & dir_b) == dir_b;
  endproperty
  a_dir: assert property (p_dir) else $error("input pin driven");
  property p_pp;
    (pad_oe_n_out & ~dir_b & ~od_b) == 8'h00;
  endproperty
  a_pp: assert property (p_pp) else $error("push-pull pin not driven");
  property p_od;
    ((pad_oe_n_out ^ pad_out) & ~dir_b & od_b) == 8'h00;
  endproperty
  a_od: assert property (p_od) else $error("open-drain enable wrong");
  property p_pad;
    pad_out == (((fn_b & alt_v) | (~fn_b & gpio_data_in)) ^ pol_b);
  endproperty
  a_pad: assert property (p_pad) else $error("pad wrong");
  property p_rsv;
    rsv_b == 8'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_rst;
    $fell(reset_in) |-> cfg_out == {8{8'h01}};
  endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  property p_main;
    (main_power_reset_in || hard_reset_in) [*4] |-> cfg_out[2] == 8'h00;
  endproperty
  a_main: assert property (p_main) else $error("pin 3.3 not cleared");
  property p_wr;
    logic [2:0] k;
    (take && hwrite_in && !main_power_reset_in && !hard_reset_in,
      k = haddr_in[4:2] + 3'd4) |=> ##1 cfg_out[k] == (8'h87 & $past(wd8));
  endproperty
  a_wr: assert property (p_wr) else $error("write not stored");
  property p_rd;
    logic [2:0] k;
    (take && !hwrite_in, k = haddr_in[4:2] + 3'd4) |=> hrdata_out == {24'h0, cfg_out[k]};
  endproperty
  a_rd: assert property (p_rd) else $error("read data wrong");
endmodule

bind gpc_bank gpc_bank_chk i_gpc_bank_chk (
  .clk_sys_in(clk_sys_in),
  .reset_in(reset_in),
  .main_power_reset_in(main_power_reset_in),
  .hard_reset_in(hard_reset_in),
  .hsel_in(hsel_in),
  .haddr_in(haddr_in),
  .htrans_in(htrans_in),
  .hwrite_in(hwrite_in),
  .hready_in(hready_in),
  .hwdata_in(hwdata_in),
  .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out),
  .gpio_data_in(gpio_data_in),
  .alt_tx_in(alt_tx_in),
  .pad_out(pad_out),
  .pad_oe_n_out(pad_oe_n_out),
  .cfg_out(cfg_out)
);

// *** gpc_params.svh ***
// constants for the gpio pin configuration bank
`ifndef GPC_PARAMS_SVH
`define GPC_PARAMS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define GPC_IDX_PIN_3_1 10'h034
`define GPC_IDX_PIN_3_2 10'h035
`define GPC_IDX_PIN_3_3 10'h036
`define GPC_IDX_PIN_3_4 10'h037
`define GPC_IDX_PIN_3_5 10'h038
`define GPC_IDX_PIN_3_6 10'h039
`define GPC_IDX_PIN_3_7 10'h03a
`define GPC_IDX_PIN_4_0 10'h03b
`define GPC_IDX_PIN_LEVEL 10'h040
`define GPC_IDX_ALT_ACTIVE 10'h041

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define GPC_BIT_DIR 0
`define GPC_BIT_POL 1
`define GPC_BIT_FUNC 2
`define GPC_BIT_DRV 7
`define GPC_CFG_WMASK 8'h87

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define GPC_CFG_RST 8'h01
`define GPC_CFG_MAIN_RST 8'h00

`endif

// *** gpc_pin_cell.sv ***
// one pin: direction, polarity, function select and driver type
`timescale 1ns/1ps
`include "gpc_params.svh"
module gpc_pin_cell import gpc_pkg::*; (
  // configuration
  input wire logic [7:0] cfg_in,
  // logic side
  input wire logic gpio_data_in,
  input wire logic alt_data_in,
  output logic gpio_level_out,
  output logic alt_level_out,
  // pad side
  input wire logic pad_sync_in,
  output logic pad_out,
  output logic pad_oe_n_out
);

  logic drive_val;
  logic in_val;

  always_comb begin
    // function select picks the source, polarity applies to both
    drive_val = (cfg_in[`GPC_BIT_FUNC] ? alt_data_in : gpio_data_in)
                ^ cfg_in[`GPC_BIT_POL];
    in_val = pad_sync_in ^ cfg_in[`GPC_BIT_POL];
    pad_out = drive_val;
    // input when dir set; open drain releases on a high level
    pad_oe_n_out = cfg_in[`GPC_BIT_DIR]
                   | (cfg_in[`GPC_BIT_DRV] & drive_val);
    gpio_level_out = cfg_in[`GPC_BIT_FUNC] ? 1'b0 : in_val;
    alt_level_out = cfg_in[`GPC_BIT_FUNC] ? in_val : 1'b0;
  end

endmodule

// *** gpc_pkg.sv ***
// types for the gpio pin configuration bank
package gpc_pkg;

  // ----------------------------------------------------------------
  // alternate function carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic fan_speed_out;
    logic smbus_data_line;
    logic irq12;
    logic keyboard_reset_out;
    logic addr20_gate_out;
    logic drive_density_sel0;
  } gpc_alt_tx_s;

  typedef struct packed {
    logic fan_tachometer_in;
    logic smbus_data_line;
    logic irq12;
    logic irq14;
  } gpc_alt_rx_s;

  // ----------------------------------------------------------------
  // ahb-lite carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } gpc_ahb_req_s;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } gpc_ahb_rsp_s;

  // ----------------------------------------------------------------
  // bank state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0][7:0] cfg;
    logic wr_pend;
    logic [2:0] wr_sel;
    logic [31:0] rdata;
  } gpc_bank_state_s;

endpackage

// *** gpc_sync2.sv ***
// two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module gpc_sync2 import gpc_pkg::*; #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } gpc_sync_state_s;

  gpc_sync_state_s st;
  gpc_sync_state_s next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.s2;

endmodule

// *** tb_gpio_pin_config_bank.sv ***
// self-checking testbench for the gpio pin configuration bank
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    check_count++; \
    if ((a) !== (b)) begin \
      err_count++; \
      $display("[FAIL] %0t got %h want %h", $time, (a), (b)); \
    end \
  end
module tb_gpio_pin_config_bank import gpc_pkg::*;;
  typedef struct packed {
    logic [7:0] wval;
    logic [7:0] rval;
    logic pad;
    logic oe_n;
  } gpc_row_s;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic main_power_reset_in = 1'b0;
  logic hard_reset_in = 1'b0;
  logic hsel_in = 1'b0;
  logic [31:0] haddr_in = 32'h0;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'b0;
  logic [2:0] hsize_in = 3'h2;
  logic [31:0] hwdata_in = 32'h0;
  logic [7:0] gpio_data_in = 8'h5a;
  gpc_alt_tx_s alt_tx_in = 6'h36;
  logic [7:0] pad_in = 8'h00;
  logic hready_in;
  logic [31:0] hrdata_out, rd;
  logic hreadyout_out, hresp_out;
  logic [7:0] gpio_level_out, pad_out, pad_oe_n_out;
  gpc_alt_rx_s alt_rx_out;
  logic [7:0][7:0] cfg_out;
  int err_count = 0;
  int check_count = 0;
  int n;
  // one row a pin, pin 3.1 first
  gpc_row_s rows [8] = '{'{8'hff, 8'h87, 1'b0, 1'b1}, '{8'h02, 8'h02, 1'b0, 1'b0},
    '{8'h04, 8'h04, 1'b1, 1'b0}, '{8'h86, 8'h86, 1'b1, 1'b1}, '{8'h78, 8'h00, 1'b1, 1'b0},
    '{8'h84, 8'h84, 1'b1, 1'b1}, '{8'h06, 8'h06, 1'b0, 1'b0}, '{8'h05, 8'h05, 1'b0, 1'b1}};
  assign hready_in = hreadyout_out;
  always #50 clk_sys_in = ~clk_sys_in;
  gpc_bank i_gpc_bank (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .main_power_reset_in(main_power_reset_in), .hard_reset_in(hard_reset_in),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hsize_in(hsize_in), .hready_in(hready_in), .hwdata_in(hwdata_in),
    .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .gpio_data_in(gpio_data_in), .gpio_level_out(gpio_level_out), .alt_tx_in(alt_tx_in),
    .alt_rx_out(alt_rx_out), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_n_out(pad_oe_n_out), .cfg_out(cfg_out));
  // ----
  // tasks
  // ----
  task automatic xfer(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
      output logic [31:0] d);
    hsel_in <= 1'b1;
    haddr_in <= {20'h0, idx, 2'b00};
    htrans_in <= 2'b10;
    hwrite_in <= wr;
    do begin
      @(posedge clk_sys_in);
    end while (hready_in !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'b00;
    hwdata_in <= {24'h0, wd};
    do begin
      @(posedge clk_sys_in);
    end while (hready_in !== 1'b1);
    d = hrdata_out;
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    repeat (3) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    for (n = 0; n < 8; n++) begin
      xfer(1'b1, 10'h034 + 10'(n), rows[n].wval, rd);
      xfer(1'b0, 10'h034 + 10'(n), 8'h00, rd);
      `CHK(rd, {24'h0, rows[n].rval})
      `CHK(pad_out[n], rows[n].pad)
      `CHK(pad_oe_n_out[n], rows[n].oe_n)
    end
    // input side: tach alt, inverted gpio, irq14 alt
    xfer(1'b1, 10'h034, 8'h05, rd);
    xfer(1'b1, 10'h035, 8'h03, rd);
    xfer(1'b1, 10'h038, 8'h05, rd);
    pad_in <= 8'h11;
    repeat (3) @(posedge clk_sys_in);
    `CHK(alt_rx_out.fan_tachometer_in, 1'b1)
    `CHK(alt_rx_out.irq14, 1'b1)
    `CHK(gpio_level_out[1:0], 2'b10)
    `CHK(alt_rx_out.irq12, 1'b1)
    `CHK(alt_rx_out.smbus_data_line, 1'b0)
    `CHK(gpio_level_out, 8'h02)
    // level view: alt levels above plain levels
    xfer(1'b0, 10'h040, 8'h00, rd);
    `CHK(rd, 32'h00005902)
    xfer(1'b0, 10'h041, 8'h00, rd);
    `CHK(rd, 32'h000000fd)
    xfer(1'b1, 10'h050, 8'hff, rd);
    xfer(1'b0, 10'h050, 8'h00, rd);
    `CHK(rd, 32'h0)
    for (n = 0; n < 2; n++) begin
      xfer(1'b1, 10'h036, 8'h87, rd);
      main_power_reset_in <= (n == 0);
      hard_reset_in <= (n == 1);
      repeat (4) @(posedge clk_sys_in);
      xfer(1'b1, 10'h036, 8'h81, rd);
      xfer(1'b0, 10'h036, 8'h00, rd);
      `CHK(rd, 32'h0)
      xfer(1'b0, 10'h037, 8'h00, rd);
      `CHK(rd, 32'h86)
      main_power_reset_in <= 1'b0;
      hard_reset_in <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
    end
    reset_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    `CHK(pad_oe_n_out, 8'hff)
    for (n = 0; n < 8; n++) begin
      xfer(1'b0, 10'h034 + 10'(n), 8'h00, rd);
      `CHK(rd, 32'h01)
    end
    end_of_test;
  end
  initial begin
    repeat (2000) @(posedge clk_sys_in);
    err_count++;
    end_of_test;
  end
endmodule
